//--- sim/ldsp_chk.sv
`timescale 1ns/1ns
`default_nettype none
// Port-level watch on band fields, lock state and pins
module ldsp_chk
    import ldsp_pkg::*;
(
    input wire logic SYS_CLK_IN,
    input wire logic SYS_RST_IN,
    input wire logic PROG_LATCH_IN,
    input wire logic CMP_VALID_IN,
    input wire logic [7:0] CMP_PHASE_ERR_IN,
    input wire logic READBACK_IN,
    input wire logic FASTLOCK_ACTIVE_IN,
    input wire logic BAND_FORCE_OUT,
    input wire logic [7:0] BAND_CODE_OUT,
    input wire logic PHASE_LOCK_OUT,
    input wire logic LOCK_PIN_OE_N_OUT,
    input wire logic MUX_PIN_O_OUT,
    input wire logic MUX_PIN_OE_N_OUT,
    input wire logic FAST_PIN_O_OUT
);
    default clocking @(posedge SYS_CLK_IN); endclocking
    default disable iff (SYS_RST_IN);
    // Reset release, and a fast-lock run long enough to settle
    sequence rst_gone;
        $fell(SYS_RST_IN);
    endsequence
    sequence fl_run;
        FASTLOCK_ACTIVE_IN [*3];
    endsequence
    chk_band_after_latch: assert property (!$stable({BAND_FORCE_OUT, BAND_CODE_OUT}) |->
        $past(PROG_LATCH_IN) || $past(PROG_LATCH_IN, 2) || $past(PROG_LATCH_IN, 3))
        else $error("band moved without latch");
    chk_reset_values: assert property (rst_gone |-> BAND_CODE_OUT == 8'h80 &&
        !PHASE_LOCK_OUT && LOCK_PIN_OE_N_OUT) else $error("bad reset state");
    chk_mux_readback: assert property (rst_gone |=> MUX_PIN_O_OUT == $past(READBACK_IN) &&
        !MUX_PIN_OE_N_OUT) else $error("mux pin not readback");
    chk_lock_hold: assert property (!CMP_VALID_IN |=> $stable(PHASE_LOCK_OUT))
        else $error("lock moved without strobe");
    chk_lock_rise: assert property ($rose(PHASE_LOCK_OUT) |-> $past(CMP_VALID_IN) &&
        $past(CMP_PHASE_ERR_IN) <= 8'hB4) else $error("lock rose without pass");
    chk_lock_fall: assert property ($fell(PHASE_LOCK_OUT) |-> $past(CMP_VALID_IN) &&
        $past(CMP_PHASE_ERR_IN) > 8'h0A) else $error("lock fell without miss");
    chk_pass_no_drop: assert property (CMP_VALID_IN && CMP_PHASE_ERR_IN <= 8'h0A
        |=> !$fell(PHASE_LOCK_OUT)) else $error("pass dropped lock");
    chk_miss_no_rise: assert property (CMP_VALID_IN && CMP_PHASE_ERR_IN > 8'hB4
        |=> !$rose(PHASE_LOCK_OUT)) else $error("miss raised lock");
    chk_fast_frozen: assert property (fl_run |-> $stable(FAST_PIN_O_OUT))
        else $error("fast pin moved in fast lock");
endmodule
bind ldsp_top ldsp_chk i_chk (.SYS_CLK_IN(SYS_CLK_IN), .SYS_RST_IN(SYS_RST_IN),
    .PROG_LATCH_IN(PROG_LATCH_IN), .CMP_VALID_IN(CMP_VALID_IN),
    .CMP_PHASE_ERR_IN(CMP_PHASE_ERR_IN), .READBACK_IN(READBACK_IN),
    .FASTLOCK_ACTIVE_IN(FASTLOCK_ACTIVE_IN), .BAND_FORCE_OUT(BAND_FORCE_OUT),
    .BAND_CODE_OUT(BAND_CODE_OUT), .PHASE_LOCK_OUT(PHASE_LOCK_OUT),
    .LOCK_PIN_OE_N_OUT(LOCK_PIN_OE_N_OUT), .MUX_PIN_O_OUT(MUX_PIN_O_OUT),
    .MUX_PIN_OE_N_OUT(MUX_PIN_OE_N_OUT), .FAST_PIN_O_OUT(FAST_PIN_O_OUT));
`default_nettype wire

//--- sim/ldsp_host.sv
`timescale 1ns/1ns
`default_nettype none
// Host on the three-wire port; random pacing gives prompt and slow words
module ldsp_host (
    input wire logic clk_in,
    output logic prog_clk_out,
    output logic prog_data_out,
    output logic prog_latch_out
);
    initial begin
        prog_clk_out = 1'b0;
        prog_data_out = 1'b0;
        prog_latch_out = 1'b0;
    end
    // Whole word MSB first, then a latch pulse
    task automatic send(input logic [31:0] w);
        int h;
        h = $urandom_range(1, 2);
        for (int i = 31; i >= 0; i--) begin
            @(posedge clk_in);
            prog_clk_out <= 1'b0;
            prog_data_out <= w[i];
            repeat (h) @(posedge clk_in);
            prog_clk_out <= 1'b1;
            repeat (h - 1) @(posedge clk_in);
        end
        // Released data shows the opposite level, never a stale bit
        @(posedge clk_in);
        prog_clk_out <= 1'b0;
        prog_data_out <= ~w[0];
        @(posedge clk_in);
        prog_latch_out <= 1'b1;
        repeat (2) @(posedge clk_in);
        prog_latch_out <= 1'b0;
    endtask
endmodule
`default_nettype wire

//--- sim/ldsp_top_bench.sv
`timescale 1ns/1ns
`default_nettype none
module ldsp_top_bench import ldsp_pkg::*;;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic pc, pd, pl, cv, nd, rd, fl, bf, lk, elk, po, poe, phi, mo, moe, mhi, fo, foe, fhi;
    logic [7:0] pe, bc;
    logic [8:0] st;
    logic [1:0] nc, rc;
    int num_errors = 0;
    int compares = 0;
    // 100 MHz clock
    always #5 clk = ~clk;
    ldsp_host i_host (.clk_in(clk), .prog_clk_out(pc), .prog_data_out(pd), .prog_latch_out(pl));
    ldsp_top i_dut (.SYS_CLK_IN(clk), .SYS_RST_IN(rst), .PROG_CLK_IN(pc), .PROG_DATA_IN(pd),
        .PROG_LATCH_IN(pl), .CMP_VALID_IN(cv), .CMP_PHASE_ERR_IN(pe), .N_DIV_PULSE_IN(nd),
        .R_DIV_PULSE_IN(rd), .VTUNE_LOCK_IN(st[0]), .READBACK_IN(st[1]),
        .ANALOG_LOCK_IN(st[2]), .REF_ACTIVE_IN(st[3]), .RF_ACTIVE_IN(st[4]),
        .CAL_RUNNING_IN(st[5]), .VTUNE_RANGE_ERR_IN(st[6]), .CAL_FAIL_LOW_IN(st[7]),
        .CAL_FAIL_HIGH_IN(st[8]), .FASTLOCK_ACTIVE_IN(fl), .BAND_FORCE_OUT(bf),
        .BAND_CODE_OUT(bc), .PHASE_LOCK_OUT(lk), .LOCK_PIN_O_OUT(po), .LOCK_PIN_OE_N_OUT(poe),
        .LOCK_PIN_HI_DRIVE_OUT(phi), .MUX_PIN_O_OUT(mo), .MUX_PIN_OE_N_OUT(moe),
        .MUX_PIN_HI_DRIVE_OUT(mhi), .FAST_PIN_O_OUT(fo), .FAST_PIN_OE_N_OUT(foe),
        .FAST_PIN_HI_DRIVE_OUT(fhi));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Window in tenths of ns; reserved codes fall back to the narrowest
    function automatic logic [7:0] win(input logic [2:0] w);
        logic [7:0] t [8] = '{8'h0A, 8'h11, 8'h1E, 8'h3C, 8'h64, 8'hB4, 8'h0A, 8'h0A};
        return t[w];
    endfunction
    // Expected {level, enable low, strong} of one pin
    function automatic logic [2:0] pexp(input logic [4:0] s, input logic i, input logic [2:0] d);
        logic [15:0] v;
        logic l;
        v = {st[8:2], rc, nc, st[1], st[0] & elk, st[0], elk, 1'b0};
        l = (s[4] ? 1'b0 : v[s[3:0]]) ^ i;
        return {l, (d == 3'h1 || d == 3'h3) ? 1'b0 : (d == 3'h2 || d == 3'h4) ? l :
            (d == 3'h5) ? ~l : 1'b1, d inside {3'h3, 3'h4, 3'h5}};
    endfunction
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    // Back-to-back strobes, then a look at the lock level
    task automatic strobe(input int n, input logic [7:0] e);
        repeat (n) begin
            @(posedge clk);
            cv <= 1'b1;
            pe <= e;
        end
        @(posedge clk);
        cv <= 1'b0;
        pe <= ~e;
        tick(2);
        #1;
        chk(32'(lk), 32'(elk));
    endtask
    task automatic stop_test;
        $display("compares %0d errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        logic [3:0] e;
        logic [9:0] t;
        logic [7:0] c;
        logic [4:0] s0, s1, s2;
        logic [2:0] d0, d1, d2, iv;
        logic [1:0] p;
        logic f;
        int n;
        void'($urandom(32'hE9AC));
        {cv, nd, rd, fl, elk, pe, nc, rc} = '0;
        st = 9'($urandom);
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        tick(2);
        #1;
        chk({bf, bc, lk, poe, mo, moe}, {1'b0, 8'h80, 1'b0, 1'b1, st[1], 1'b0});
        // Band writes: both ends of the code, then back to midscale
        for (int i = 0; i < 6; i++) begin
            c = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : (i == 5) ? 8'h80 : 8'($urandom);
            f = (i == 5) ? 1'b0 : 1'($urandom);
            i_host.send({19'h0, f, c, LDSP_ADDR_BAND});
            tick(4);
            #1;
            chk({bf, bc}, {f, c});
        end
        // Lock detector per window code; first round keeps reset settings
        for (int w = 0; w < 8; w++) begin
            e = (w == 0) ? 4'h4 : 4'($urandom_range(0, 5));
            t = (w == 0) ? 10'h020 : 10'($urandom_range(0, 3));
            n = (t == 0) ? 1 : 8 * t;
            if (w != 0) i_host.send({e, t, 3'(w), 11'h000, LDSP_ADDR_LOCK});
            strobe(e, win(3'(w)) + 8'h01);
            elk = 1'b0;
            strobe(1, win(3'(w)) + 8'h01);
            strobe(n - 1, win(3'(w)));
            elk = 1'b1;
            strobe(1, win(3'(w)));
        end
        // Pin routing, drivers and inversion over random status inputs
        for (int i = 0; i < 48; i++) begin
            p = 2'($urandom);
            @(posedge clk);
            {fl, nd, rd} <= {1'b0, p};
            st <= 9'($urandom);
            @(posedge clk);
            {nd, rd} <= 2'b00;
            // Feedback pulse rides on p[1], reference pulse on p[0]
            nc = nc + 2'(p[1]);
            rc = rc + 2'(p[0]);
            s0 = (i < 16) ? 5'(i) : 5'($urandom);
            {s1, s2, d1, d2, iv} = 19'($urandom);
            d0 = 3'(i);
            i_host.send({1'b0, s2, d2, iv[2], s1, d1, iv[1], s0, iv[0], d0, LDSP_ADDR_PINS});
            // Hidden tuning registers only ever get their fixed words
            if (i % 16 == 0) begin
                i_host.send((i == 0) ? 32'h210050CA : (i == 16) ? 32'h03C7C039 : 32'h207DDBF8);
            end
            tick(2);
            fl <= 1'($urandom);
            tick(4);
            #1;
            chk({po, poe, phi}, pexp(s0, iv[0], d0));
            chk({mo, moe, mhi}, pexp(s1, iv[1], d1));
            chk({fo, foe, fhi}, pexp(fl ? 5'h00 : s2, iv[2], d2));
        end
        stop_test;
    end
    // Watchdog far beyond the expected run
    initial begin
        repeat (50000) @(posedge clk);
        num_errors++;
        stop_test;
    end
endmodule
`default_nettype wire

//--- verilog/ldsp_pin_drive.sv
`timescale 1ns/1ns
`default_nettype none
// One status pin: source select, inversion and driver type
module ldsp_pin_drive
    import ldsp_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [LDSP_NSRC-1:0] src_vec_in,
    input wire logic [4:0] src_sel_in,
    input wire logic inv_in,
    input wire logic [2:0] drv_in,
    input wire logic force_en_in,
    input wire logic force_val_in,
    output logic pin_o_out,
    output logic pin_oe_n_out,
    output logic pin_hi_drive_out
);
    logic lvl;
    logic o_d, o_q, oe_n_d, oe_n_q, hd_d, hd_q;

    // Pick and invert the level; reserved sources read as ground
    always_comb begin
        if (force_en_in) begin
            lvl = force_val_in;
        end else if (src_sel_in < 5'(LDSP_NSRC)) begin
            lvl = src_vec_in[src_sel_in[3:0]];
        end else begin
            lvl = 1'b0;
        end
        lvl = lvl ^ inv_in;
    end

    // Driver type decides when the pin is actually driven
    always_comb begin
        o_d = lvl;
        oe_n_d = 1'b1;
        hd_d = 1'b0;
        unique case (drv_in)
            3'h1: oe_n_d = 1'b0;
            3'h2: oe_n_d = lvl;
            3'h3: begin
                oe_n_d = 1'b0;
                hd_d = 1'b1;
            end
            3'h4: begin
                oe_n_d = lvl;
                hd_d = 1'b1;
            end
            3'h5: begin
                oe_n_d = ~lvl;
                hd_d = 1'b1;
            end
            default: oe_n_d = 1'b1; // Off and reserved codes float
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            o_q <= 1'b0;
            oe_n_q <= 1'b1;
            hd_q <= 1'b0;
        end else begin
            o_q <= o_d;
            oe_n_q <= oe_n_d;
            hd_q <= hd_d;
        end
    end

    assign pin_o_out = o_q;
    assign pin_oe_n_out = oe_n_q;
    assign pin_hi_drive_out = hd_q;
endmodule
`default_nettype wire

//--- verilog/ldsp_pkg.sv
`default_nettype none
package ldsp_pkg;
    // Register addresses carried in the low nibble of each serial word
    localparam logic [3:0] LDSP_ADDR_BAND = 4'hF;
    localparam logic [3:0] LDSP_ADDR_LOCK = 4'hD;
    localparam logic [3:0] LDSP_ADDR_PINS = 4'h7;
    localparam int LDSP_WORD_W = 32;
    // Band control fields
    localparam int LDSP_BAND_FORCE_BIT = 12;
    localparam int LDSP_BAND_CODE_LSB = 4;
    localparam logic LDSP_BAND_FORCE_RST = 1'h0;
    localparam logic [7:0] LDSP_BAND_CODE_RST = 8'h80;
    // Lock detect fields
    localparam int LDSP_ERR_LSB = 28;
    localparam int LDSP_PASS_LSB = 18;
    localparam int LDSP_WIN_LSB = 15;
    localparam logic [3:0] LDSP_ERR_RST = 4'h4;
    localparam logic [9:0] LDSP_PASS_RST = 10'h020;
    localparam logic [2:0] LDSP_WIN_RST = 3'h0;
    // Pass target is scaled by eight, a shift of three
    localparam int LDSP_PASS_SHIFT = 3;
    // Phase error windows in tenths of a nanosecond
    localparam logic [7:0] LDSP_WIN_0 = 8'h0A;
    localparam logic [7:0] LDSP_WIN_1 = 8'h11;
    localparam logic [7:0] LDSP_WIN_2 = 8'h1E;
    localparam logic [7:0] LDSP_WIN_3 = 8'h3C;
    localparam logic [7:0] LDSP_WIN_4 = 8'h64;
    localparam logic [7:0] LDSP_WIN_5 = 8'hB4;
    // Status pin configuration fields
    localparam int LDSP_FL_SRC_LSB = 26;
    localparam int LDSP_FL_DRV_LSB = 23;
    localparam int LDSP_FASTLOCK_PIN_INVERT_BIT = 22;
    localparam int LDSP_MUX_SRC_LSB = 17;
    localparam int LDSP_MUX_DRV_LSB = 14;
    localparam int LDSP_MUX_PIN_INVERT_BIT = 13;
    localparam int LDSP_LK_SRC_LSB = 8;
    localparam int LDSP_LK_INV_BIT = 7;
    localparam int LDSP_LK_DRV_LSB = 4;
    localparam logic [4:0] LDSP_SRC_RST = 5'h00;
    localparam logic [4:0] LDSP_MUX_SRC_RST = 5'h04;
    localparam logic [2:0] LDSP_DRV_RST = 3'h0;
    localparam logic [2:0] LDSP_MUX_DRV_RST = 3'h1;
    localparam logic LDSP_INV_RST = 1'h0;
    // Pin driver types
    typedef enum logic [2:0] {
        LDSP_DRV_HIZ = 3'b000,
        LDSP_DRV_PP = 3'b001,
        LDSP_DRV_OD = 3'b010,
        LDSP_DRV_HPP = 3'b011,
        LDSP_DRV_HOD = 3'b100,
        LDSP_DRV_HOS = 3'b101
    } ldsp_drv_t;
    // Number of defined status sources
    localparam int LDSP_NSRC = 16;
endpackage
`default_nettype wire

//--- verilog/ldsp_top.sv
`timescale 1ns/1ns
`default_nettype none
module ldsp_top
    import ldsp_pkg::*;
(
    input wire logic SYS_CLK_IN,
    input wire logic SYS_RST_IN,
    input wire logic PROG_CLK_IN,
    input wire logic PROG_DATA_IN,
    input wire logic PROG_LATCH_IN,
    input wire logic CMP_VALID_IN,
    input wire logic [7:0] CMP_PHASE_ERR_IN,
    input wire logic N_DIV_PULSE_IN,
    input wire logic R_DIV_PULSE_IN,
    input wire logic VTUNE_LOCK_IN,
    input wire logic READBACK_IN,
    input wire logic ANALOG_LOCK_IN,
    input wire logic REF_ACTIVE_IN,
    input wire logic RF_ACTIVE_IN,
    input wire logic CAL_RUNNING_IN,
    input wire logic VTUNE_RANGE_ERR_IN,
    input wire logic CAL_FAIL_LOW_IN,
    input wire logic CAL_FAIL_HIGH_IN,
    input wire logic FASTLOCK_ACTIVE_IN,
    output logic BAND_FORCE_OUT,
    output logic [7:0] BAND_CODE_OUT,
    output logic PHASE_LOCK_OUT,
    output logic LOCK_PIN_O_OUT,
    output logic LOCK_PIN_OE_N_OUT,
    output logic LOCK_PIN_HI_DRIVE_OUT,
    output logic MUX_PIN_O_OUT,
    output logic MUX_PIN_OE_N_OUT,
    output logic MUX_PIN_HI_DRIVE_OUT,
    output logic FAST_PIN_O_OUT,
    output logic FAST_PIN_OE_N_OUT,
    output logic FAST_PIN_HI_DRIVE_OUT
);
    // Serial shifter state and configuration fields
    logic sclk_q, sclk_d, lat_q, lat_d;
    logic [LDSP_WORD_W-1:0] shift_q, shift_d;
    logic band_force_q, band_force_d;
    logic [7:0] band_code_q, band_code_d;
    logic [3:0] err_allow_q, err_allow_d;
    logic [9:0] pass_tgt_q, pass_tgt_d;
    logic [2:0] win_sel_q, win_sel_d;
    logic [4:0] fl_src_q, fl_src_d, mux_src_q, mux_src_d, lk_src_q, lk_src_d;
    logic [2:0] fl_drv_q, fl_drv_d, mux_drv_q, mux_drv_d, lk_drv_q, lk_drv_d;
    logic fastlock_pin_invert_q, fastlock_pin_invert_d, mux_pin_invert_q, mux_pin_invert_d, lk_inv_q, lk_inv_d;
    logic word_done;

    // Word shifts in MSB first on program clock rises, applied on latch rise
    always_comb begin
        sclk_d = PROG_CLK_IN;
        lat_d = PROG_LATCH_IN;
        shift_d = shift_q;
        if (PROG_CLK_IN && !sclk_q) begin
            shift_d = {shift_q[LDSP_WORD_W-2:0], PROG_DATA_IN};
        end
        word_done = PROG_LATCH_IN && !lat_q;
    end

    // Register decode; undisclosed addresses are accepted and dropped
    always_comb begin
        band_force_d = band_force_q;
        band_code_d = band_code_q;
        err_allow_d = err_allow_q;
        pass_tgt_d = pass_tgt_q;
        win_sel_d = win_sel_q;
        fl_src_d = fl_src_q;
        fl_drv_d = fl_drv_q;
        fastlock_pin_invert_d = fastlock_pin_invert_q;
        mux_src_d = mux_src_q;
        mux_drv_d = mux_drv_q;
        mux_pin_invert_d = mux_pin_invert_q;
        lk_src_d = lk_src_q;
        lk_drv_d = lk_drv_q;
        lk_inv_d = lk_inv_q;
        if (word_done) begin
            if (shift_q[3:0] == LDSP_ADDR_BAND) begin
                band_force_d = shift_q[LDSP_BAND_FORCE_BIT];
                band_code_d = shift_q[LDSP_BAND_CODE_LSB +: 8];
            end
            if (shift_q[3:0] == LDSP_ADDR_LOCK) begin
                err_allow_d = shift_q[LDSP_ERR_LSB +: 4];
                pass_tgt_d = shift_q[LDSP_PASS_LSB +: 10];
                win_sel_d = shift_q[LDSP_WIN_LSB +: 3];
            end
            if (shift_q[3:0] == LDSP_ADDR_PINS) begin
                fl_src_d = shift_q[LDSP_FL_SRC_LSB +: 5];
                fl_drv_d = shift_q[LDSP_FL_DRV_LSB +: 3];
                fastlock_pin_invert_d = shift_q[LDSP_FASTLOCK_PIN_INVERT_BIT];
                mux_src_d = shift_q[LDSP_MUX_SRC_LSB +: 5];
                mux_drv_d = shift_q[LDSP_MUX_DRV_LSB +: 3];
                mux_pin_invert_d = shift_q[LDSP_MUX_PIN_INVERT_BIT];
                lk_src_d = shift_q[LDSP_LK_SRC_LSB +: 5];
                lk_drv_d = shift_q[LDSP_LK_DRV_LSB +: 3];
                lk_inv_d = shift_q[LDSP_LK_INV_BIT];
            end
        end
    end

    always_ff @(posedge SYS_CLK_IN) begin
        if (SYS_RST_IN) begin
            sclk_q <= 1'b0;
            lat_q <= 1'b0;
            shift_q <= '0;
            band_force_q <= LDSP_BAND_FORCE_RST;
            band_code_q <= LDSP_BAND_CODE_RST;
            err_allow_q <= LDSP_ERR_RST;
            pass_tgt_q <= LDSP_PASS_RST;
            win_sel_q <= LDSP_WIN_RST;
            fl_src_q <= LDSP_SRC_RST;
            fl_drv_q <= LDSP_DRV_RST;
            fastlock_pin_invert_q <= LDSP_INV_RST;
            mux_src_q <= LDSP_MUX_SRC_RST;
            mux_drv_q <= LDSP_MUX_DRV_RST;
            mux_pin_invert_q <= LDSP_INV_RST;
            lk_src_q <= LDSP_SRC_RST;
            lk_drv_q <= LDSP_DRV_RST;
            lk_inv_q <= LDSP_INV_RST;
        end else begin
            sclk_q <= sclk_d;
            lat_q <= lat_d;
            shift_q <= shift_d;
            band_force_q <= band_force_d;
            band_code_q <= band_code_d;
            err_allow_q <= err_allow_d;
            pass_tgt_q <= pass_tgt_d;
            win_sel_q <= win_sel_d;
            fl_src_q <= fl_src_d;
            fl_drv_q <= fl_drv_d;
            fastlock_pin_invert_q <= fastlock_pin_invert_d;
            mux_src_q <= mux_src_d;
            mux_drv_q <= mux_drv_d;
            mux_pin_invert_q <= mux_pin_invert_d;
            lk_src_q <= lk_src_d;
            lk_drv_q <= lk_drv_d;
            lk_inv_q <= lk_inv_d;
        end
    end

    assign BAND_FORCE_OUT = band_force_q;
    assign BAND_CODE_OUT = band_code_q;

    // Lock detector state
    logic [7:0] win;
    logic in_win;
    logic [12:0] pass_cnt_q, pass_cnt_d;
    logic [4:0] err_cnt_q, err_cnt_d;
    logic locked_q, locked_d;
    logic [12:0] pass_need;

    // Window per code; reserved codes fall back to the tightest window
    always_comb begin
        unique case (win_sel_q)
            3'h1: win = LDSP_WIN_1;
            3'h2: win = LDSP_WIN_2;
            3'h3: win = LDSP_WIN_3;
            3'h4: win = LDSP_WIN_4;
            3'h5: win = LDSP_WIN_5;
            default: win = LDSP_WIN_0;
        endcase
        in_win = CMP_PHASE_ERR_IN <= win;
    end

    // Counting runs only on comparison strobes, so the level never chatters
    always_comb begin
        pass_need = 13'(pass_tgt_q) << LDSP_PASS_SHIFT;
        pass_cnt_d = pass_cnt_q;
        err_cnt_d = err_cnt_q;
        locked_d = locked_q;
        if (CMP_VALID_IN) begin
            if (in_win) begin
                if (pass_cnt_q + 13'h0001 >= pass_need) begin
                    locked_d = 1'b1;
                    pass_cnt_d = '0;
                    err_cnt_d = '0;
                end else begin
                    pass_cnt_d = pass_cnt_q + 13'h0001;
                end
            end else if (err_cnt_q + 5'h01 > 5'(err_allow_q)) begin
                locked_d = 1'b0;
                pass_cnt_d = '0;
                err_cnt_d = '0;
            end else begin
                err_cnt_d = err_cnt_q + 5'h01;
            end
        end
    end

    always_ff @(posedge SYS_CLK_IN) begin
        if (SYS_RST_IN) begin
            pass_cnt_q <= '0;
            err_cnt_q <= '0;
            locked_q <= 1'b0;
        end else begin
            pass_cnt_q <= pass_cnt_d;
            err_cnt_q <= err_cnt_d;
            locked_q <= locked_d;
        end
    end

    assign PHASE_LOCK_OUT = locked_q;

    // Divider pulses feed two-bit counters giving divide by 2 and 4
    logic [1:0] n_div_q, n_div_d, r_div_q, r_div_d;
    always_comb begin
        n_div_d = N_DIV_PULSE_IN ? n_div_q + 2'h1 : n_div_q;
        r_div_d = R_DIV_PULSE_IN ? r_div_q + 2'h1 : r_div_q;
    end

    always_ff @(posedge SYS_CLK_IN) begin
        if (SYS_RST_IN) begin
            n_div_q <= 2'h0;
            r_div_q <= 2'h0;
        end else begin
            n_div_q <= n_div_d;
            r_div_q <= r_div_d;
        end
    end

    // Source vector indexed by select code
    logic [LDSP_NSRC-1:0] src;
    assign src = {CAL_FAIL_HIGH_IN, CAL_FAIL_LOW_IN, VTUNE_RANGE_ERR_IN, CAL_RUNNING_IN,
                  RF_ACTIVE_IN, REF_ACTIVE_IN, ANALOG_LOCK_IN, r_div_q[1], r_div_q[0],
                  n_div_q[1], n_div_q[0], READBACK_IN, locked_q & VTUNE_LOCK_IN,
                  VTUNE_LOCK_IN, locked_q, 1'b0};

    ldsp_pin_drive u_lock_pin (
        .clk_in(SYS_CLK_IN),
        .rst_in(SYS_RST_IN),
        .src_vec_in(src),
        .src_sel_in(lk_src_q),
        .inv_in(lk_inv_q),
        .drv_in(lk_drv_q),
        .force_en_in(1'b0),
        .force_val_in(1'b0),
        .pin_o_out(LOCK_PIN_O_OUT),
        .pin_oe_n_out(LOCK_PIN_OE_N_OUT),
        .pin_hi_drive_out(LOCK_PIN_HI_DRIVE_OUT)
    );

    ldsp_pin_drive u_mux_pin (
        .clk_in(SYS_CLK_IN),
        .rst_in(SYS_RST_IN),
        .src_vec_in(src),
        .src_sel_in(mux_src_q),
        .inv_in(mux_pin_invert_q),
        .drv_in(mux_drv_q),
        .force_en_in(1'b0),
        .force_val_in(1'b0),
        .pin_o_out(MUX_PIN_O_OUT),
        .pin_oe_n_out(MUX_PIN_OE_N_OUT),
        .pin_hi_drive_out(MUX_PIN_HI_DRIVE_OUT)
    );

    // Fast lock pin takes level 0 before inversion while fast lock runs, select ignored
    ldsp_pin_drive u_fast_pin (
        .clk_in(SYS_CLK_IN),
        .rst_in(SYS_RST_IN),
        .src_vec_in(src),
        .src_sel_in(fl_src_q),
        .inv_in(fastlock_pin_invert_q),
        .drv_in(fl_drv_q),
        .force_en_in(FASTLOCK_ACTIVE_IN),
        .force_val_in(1'b0),
        .pin_o_out(FAST_PIN_O_OUT),
        .pin_oe_n_out(FAST_PIN_OE_N_OUT),
        .pin_hi_drive_out(FAST_PIN_HI_DRIVE_OUT)
    );
endmodule
`default_nettype wire
